/* File: common/eds_pkg.sv */
// Shared constants for the panel drive waveform sequencer.
// Assumes a classic Wishbone slave with byte addresses and 32-bit data.
package eds_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_PWR0 = 8'h00;
  localparam logic [7:0] OFS_PWR1 = 8'h04;
  localparam logic [7:0] OFS_CTL = 8'h08;
  localparam logic [7:0] OFS_TRIG = 8'h0C;
  localparam logic [7:0] OFS_INTF = 8'h10;
  localparam logic [7:0] OFS_INTE = 8'h14;
  localparam logic [7:0] OFS_OUTEN = 8'h18;
  localparam logic [7:0] OFS_SEGEN0 = 8'h1C;
  localparam logic [7:0] OFS_SEGEN1 = 8'h20;
  localparam logic [7:0] OFS_PLDATA = 8'h24;
  localparam logic [7:0] OFS_SEGD0 = 8'h28;
  localparam logic [7:0] OFS_SEGD1 = 8'h2C;
  localparam logic [7:0] OFS_WAVE = 8'h80;

  // ==========================================================
  // Writable masks and reset values
  localparam logic [31:0] MASK_PWR0 = 32'h0000_0F1F;
  localparam logic [31:0] MASK_PWR1 = 32'h0000_0F3F;
  localparam logic [31:0] MASK_CTL = 32'h0000_0037;
  localparam logic [31:0] MASK_WAVE = 32'h0000_BFFF;
  localparam logic [31:0] RST_PWR0 = 32'h0000_0000;
  localparam logic [31:0] RST_PWR1 = 32'h0000_0000;
  localparam logic [31:0] RST_CTL = 32'h0000_0000;
  localparam logic [15:0] RST_WAVE = 16'h0000;

  // ==========================================================
  // Field positions
  localparam int PW0_REF_ON = 0;
  localparam int PW0_REF_SEL = 1;
  localparam int PW0_DBL_ON = 2;
  localparam int PW0_DBL_BYP = 3;
  localparam int PW0_REF_HVY = 4;
  localparam int PW0_REF_CON = 8;
  localparam int PW1_HV_ON = 0;
  localparam int PW1_BST_ON = 1;
  localparam int PW1_BST_PLD = 2;
  localparam int PW1_HV_HVY = 3;
  localparam int PW1_HV_SEL = 4;
  localparam int PW1_HV_CON = 8;
  localparam int CTL_ON = 0;
  localparam int CTL_DRAIN = 1;
  localparam int CTL_DIRECT = 2;
  localparam int CTL_MAP = 4;
  localparam int W_LAST = 15;
  localparam int W_FLOAT = 13;
  localparam int W_TP = 12;
  localparam int W_LVL = 8;
  localparam logic [1:0] HV_SEL_BAD = 2'h3;

  // ==========================================================
  // Sizes
  localparam int SEG_N = 42;
  localparam int PIN_N = SEG_N + 1;
  localparam int SET_N = 32;
  localparam logic [4:0] LAST_SET = 5'h1F;

  typedef enum logic {SEQ_IDLE, SEQ_RUN} eds_seq_state_type;

endpackage : eds_pkg

/* File: rtl/eds_pin_cell.sv */
// One segment or back-plane driver: picks level, enable and float state.
// Assumes all select inputs come from logic on the same clock.
module eds_pin_cell (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic en_i,
  input wire logic direct_i,
  input wire logic wave_i,
  input wire logic float_i,
  input wire logic [3:0] levels_i,
  input wire logic cur_i,
  input wire logic tgt_i,
  input wire logic direct_lvl_i,
  output logic pin_o,
  output logic oe_n_o
);

  // ==========================================================
  // Registered pin level and enable, floating from reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o <= 1'b0;
      oe_n_o <= 1'b1;
    end else if (ce_i) begin
      if (!en_i) begin
        oe_n_o <= 1'b1;
      end else if (direct_i) begin
        pin_o <= direct_lvl_i;
        oe_n_o <= 1'b0;
      end else if (wave_i && !float_i) begin
        // Current/next pair picks ww, wb, bw or bb
        pin_o <= levels_i[{cur_i, tgt_i}];
        oe_n_o <= 1'b0;
      end else begin
        oe_n_o <= 1'b1;
      end
    end
  end

endmodule : eds_pin_cell

/* File: rtl/eds_seq_engine.sv */
// Timing-set stepper: walks set indices and counts each set's period.
// Assumes the timing-set word for idx_o is presented the same cycle.
module eds_seq_engine
  import eds_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic last_i,
  input wire logic [7:0] dur_i,
  output logic [4:0] idx_o,
  output logic active_o,
  output logic done_o
);
  import eds_pkg::*;

  eds_seq_state_type state_r;
  logic [7:0] cnt_r;
  logic [4:0] idx_r;
  logic at_end;
  logic final_set;

  // ==========================================================
  // End of period and end of waveform
  assign at_end = (state_r == SEQ_RUN) && (cnt_r == dur_i);
  // Set 31 ends the run even when unmarked
  assign final_set = at_end && (last_i || idx_r == LAST_SET);
  assign done_o = final_set && ce_i;
  assign active_o = (state_r == SEQ_RUN);
  assign idx_o = idx_r;

  // State, index and period counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= SEQ_IDLE;
      cnt_r <= 8'h00;
      idx_r <= 5'h00;
    end else if (ce_i) begin
      unique case (state_r)
        SEQ_IDLE: begin
          if (start_i) begin
            state_r <= SEQ_RUN;
            idx_r <= 5'h00;
            cnt_r <= 8'h00;
          end
        end
        SEQ_RUN: begin
          if (final_set) begin
            state_r <= SEQ_IDLE;
          end else if (at_end) begin
            idx_r <= idx_r + 5'h01;
            cnt_r <= 8'h00;
          end else begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Checks
  a_first_set_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && start_i && !active_o) |=> (active_o && idx_o == 5'h00))
    else $error("run did not begin at set 0");
  a_step_in_order: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && at_end && !final_set) |=> (idx_o == $past(idx_o) + 5'h01))
    else $error("set index did not advance by one");
  a_end_on_last: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && at_end && (last_i || idx_o == 5'h1F)) |=> !active_o)
    else $error("run did not end after final set");
  a_hold_period: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && active_o && !at_end) |=> (active_o && idx_o == $past(idx_o)))
    else $error("set left before its period ran out");
  a_restart_blocked: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && active_o && start_i && !at_end) |=> (cnt_r == $past(cnt_r) + 8'h01))
    else $error("busy run was restarted");
  c_run_to_end: cover property (@(posedge clk_i) disable iff (rst_i)
    done_o && idx_o != 5'h00);

endmodule : eds_seq_engine

/* File: rtl/eds_waveform_ctrl.sv */
// Panel drive controller: power-chain controls, timing-set memory,
// waveform sequencer and direct pin drive behind a Wishbone slave.
// Assumes one clock (the panel timing clock) and a synchronous reset.

// Functional notes
// - Booster pulldown grounds booster output
// - High-voltage output selects one of three levels
// - Two 4-bit contrast fields, sixteen steps
// - Controller works only when on; drain bit
// - Mode bit picks waveform or direct
// - Direct mode drives pins from software levels
// - Pins driven only when their enable set
// - Done flag write-one-clear, enable gates interrupt
// - Thirty-two separately addressed 15-bit timing sets
// - Trigger starts at set 0, steps upward
// - Last-set bit ends run; pins float
// - Float bit floats segments and back plane
// - Set bit 12 drives top plane level
// - Bits 11..8 give level per transition
// - Set lasts duration field plus one clocks
// - Keep current and next data per pin
// - Busy flag rises on trigger, falls at end
module eds_waveform_ctrl
  import eds_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  output logic ref_reg_power_o,
  output logic ref_level_select_o,
  output logic doubler_power_o,
  output logic doubler_bypass_o,
  output logic ref_reg_heavy_load_o,
  output logic [3:0] ref_reg_contrast_o,
  output logic hv_reg_power_o,
  output logic booster_power_o,
  output logic booster_pulldown_o,
  output logic hv_reg_heavy_load_o,
  output logic [1:0] hv_level_select_o,
  output logic [3:0] hv_reg_contrast_o,
  output logic pin_drain_enable_o,
  output logic [1:0] driver_map_select_o,
  output logic refresh_active_o,
  output logic [SEG_N-1:0] segment_pin_o,
  output logic [SEG_N-1:0] segment_pin_oe_n_o,
  output logic back_plane_pin_o,
  output logic back_plane_pin_oe_n_o,
  output logic top_plane_pin_o,
  output logic top_plane_pin_oe_n_o
);
  import eds_pkg::*;

  // ==========================================================
  // Declarations
  logic ack_r;
  logic [31:0] rdat_r;
  logic [31:0] pwr0_r;
  logic [31:0] pwr1_r;
  logic [31:0] ctl_r;
  logic refresh_done_flag_r;
  logic refresh_done_irq_en_r;
  logic top_plane_out_en_r;
  logic back_plane_out_en_r;
  logic [SEG_N-1:0] segment_out_en_r;
  logic top_plane_level_r;
  logic [PIN_N-1:0] nxt_r;
  logic [PIN_N-1:0] cur_r;
  logic [PIN_N-1:0] tgt_r;
  logic [15:0] wave_mem [SET_N];
  logic acc;
  logic wr;
  logic wave_hit;
  logic [4:0] wave_widx;
  logic [31:0] wmask;
  logic [31:0] rd_mux;
  logic [31:0] pwr1_nxt;
  logic controller_on;
  logic direct_drive_select;
  logic refresh_kick;
  logic seq_start;
  logic seq_done;
  logic seq_active;
  logic [4:0] seq_idx;
  logic [15:0] cur_word;
  logic wave_drive;
  logic direct_drive;
  logic [PIN_N-1:0] pin_en;
  logic [PIN_N-1:0] pin_lvl;
  logic [PIN_N-1:0] pin_oe_n;

  // ==========================================================
  // Wishbone decode: one wait state, ack drops after one cycle
  assign acc = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr = acc && wb_we_i;
  assign wave_hit = wb_adr_i[7];
  assign wave_widx = wb_adr_i[6:2];
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // Byte enables to a bit mask
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{wb_sel_i[b]}};
    end
  end

  // Ack and registered read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_r <= acc;
      if (acc && !wb_we_i) begin
        rdat_r <= rd_mux;
      end
    end
  end

  // Read mux; unmapped words read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (wave_hit) begin
      rd_mux = {16'h0000, wave_mem[wave_widx]};
    end else begin
      unique case ({wb_adr_i[7:2], 2'b00})
        OFS_PWR0: rd_mux = pwr0_r;
        OFS_PWR1: rd_mux = pwr1_r;
        OFS_CTL: rd_mux = ctl_r;
        OFS_TRIG: rd_mux = {31'h0, seq_active};
        OFS_INTF: rd_mux = {30'h0, seq_active, refresh_done_flag_r};
        OFS_INTE: rd_mux = {31'h0, refresh_done_irq_en_r};
        OFS_OUTEN: rd_mux = {30'h0, back_plane_out_en_r,
                             top_plane_out_en_r};
        OFS_SEGEN0: rd_mux = segment_out_en_r[31:0];
        OFS_SEGEN1: rd_mux = {22'h0, segment_out_en_r[SEG_N-1:32]};
        OFS_PLDATA: rd_mux = {30'h0, nxt_r[SEG_N], top_plane_level_r};
        OFS_SEGD0: rd_mux = nxt_r[31:0];
        OFS_SEGD1: rd_mux = {22'h0, nxt_r[SEG_N-1:32]};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Power chain registers
  always_comb begin
    pwr1_nxt = ((pwr1_r & ~wmask) | (wb_dat_i & wmask)) & MASK_PWR1;
    // Fourth code is not a level: keep the old choice
    if (pwr1_nxt[PW1_HV_SEL +: 2] == HV_SEL_BAD) begin
      pwr1_nxt[PW1_HV_SEL +: 2] = pwr1_r[PW1_HV_SEL +: 2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr0_r <= RST_PWR0;
      pwr1_r <= RST_PWR1;
      ctl_r <= RST_CTL;
    end else if (ce_i && wr && !wave_hit) begin
      if ({wb_adr_i[7:2], 2'b00} == OFS_PWR0) begin
        pwr0_r <= ((pwr0_r & ~wmask) | (wb_dat_i & wmask)) & MASK_PWR0;
      end
      if ({wb_adr_i[7:2], 2'b00} == OFS_PWR1) begin
        pwr1_r <= pwr1_nxt;
      end
      if ({wb_adr_i[7:2], 2'b00} == OFS_CTL) begin
        ctl_r <= ((ctl_r & ~wmask) | (wb_dat_i & wmask)) & MASK_CTL;
      end
    end
  end

  // Analog control levels; sequencing waits are up to software
  assign ref_reg_power_o = pwr0_r[PW0_REF_ON];
  assign ref_level_select_o = pwr0_r[PW0_REF_SEL];
  assign doubler_power_o = pwr0_r[PW0_DBL_ON];
  assign doubler_bypass_o = pwr0_r[PW0_DBL_BYP];
  assign ref_reg_heavy_load_o = pwr0_r[PW0_REF_HVY];
  assign ref_reg_contrast_o = pwr0_r[PW0_REF_CON +: 4];
  assign hv_reg_power_o = pwr1_r[PW1_HV_ON];
  assign booster_power_o = pwr1_r[PW1_BST_ON];
  assign booster_pulldown_o = pwr1_r[PW1_BST_PLD];
  assign hv_reg_heavy_load_o = pwr1_r[PW1_HV_HVY];
  assign hv_level_select_o = pwr1_r[PW1_HV_SEL +: 2];
  assign hv_reg_contrast_o = pwr1_r[PW1_HV_CON +: 4];
  assign controller_on = ctl_r[CTL_ON];
  assign direct_drive_select = ctl_r[CTL_DIRECT];
  assign pin_drain_enable_o = ctl_r[CTL_DRAIN];
  assign driver_map_select_o = ctl_r[CTL_MAP +: 2];

  // ==========================================================
  // Output enables and display data (next and top plane)
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      top_plane_out_en_r <= 1'b0;
      back_plane_out_en_r <= 1'b0;
      segment_out_en_r <= '0;
      top_plane_level_r <= 1'b0;
      nxt_r <= '0;
    end else if (ce_i && wr && !wave_hit) begin
      unique case ({wb_adr_i[7:2], 2'b00})
        OFS_OUTEN: begin
          if (wb_sel_i[0]) begin
            top_plane_out_en_r <= wb_dat_i[0];
            back_plane_out_en_r <= wb_dat_i[1];
          end
        end
        OFS_SEGEN0: begin
          segment_out_en_r[31:0] <= (segment_out_en_r[31:0] & ~wmask)
                                    | (wb_dat_i & wmask);
        end
        OFS_SEGEN1: begin
          segment_out_en_r[SEG_N-1:32] <=
            (segment_out_en_r[SEG_N-1:32] & ~wmask[9:0])
            | (wb_dat_i[9:0] & wmask[9:0]);
        end
        OFS_PLDATA: begin
          if (wb_sel_i[0]) begin
            top_plane_level_r <= wb_dat_i[0];
            nxt_r[SEG_N] <= wb_dat_i[1];
          end
        end
        OFS_SEGD0: begin
          nxt_r[31:0] <= (nxt_r[31:0] & ~wmask) | (wb_dat_i & wmask);
        end
        OFS_SEGD1: begin
          nxt_r[SEG_N-1:32] <= (nxt_r[SEG_N-1:32] & ~wmask[9:0])
                               | (wb_dat_i[9:0] & wmask[9:0]);
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Timing-set memory, one word per set, bit 14 held at zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < SET_N; i++) begin
        wave_mem[i] <= RST_WAVE;
      end
    end else if (ce_i && wr && wave_hit) begin
      wave_mem[wave_widx] <= ((wave_mem[wave_widx] & ~wmask[15:0])
        | (wb_dat_i[15:0] & wmask[15:0])) & MASK_WAVE[15:0];
    end
  end

  assign cur_word = wave_mem[seq_idx];

  // ==========================================================
  // Trigger: waveform mode only, dropped while a run is busy
  assign refresh_kick = wr && !wave_hit && wb_sel_i[0] && wb_dat_i[0]
                        && ({wb_adr_i[7:2], 2'b00} == OFS_TRIG);
  assign seq_start = refresh_kick && controller_on
                     && !direct_drive_select && !seq_active;

  eds_seq_engine u_seq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .start_i(seq_start),
    .last_i(cur_word[W_LAST]),
    .dur_i(cur_word[7:0]),
    .idx_o(seq_idx),
    .active_o(seq_active),
    .done_o(seq_done)
  );

  assign refresh_active_o = seq_active;

  // Pair of data per pin: target taken at trigger, current at done
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_r <= '0;
      tgt_r <= '0;
    end else if (ce_i) begin
      if (seq_start) begin
        tgt_r <= nxt_r;
      end
      if (seq_done) begin
        cur_r <= tgt_r;
      end
    end
  end

  // Done flag: a set in the clearing cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      refresh_done_flag_r <= 1'b0;
      refresh_done_irq_en_r <= 1'b0;
    end else if (ce_i) begin
      if (seq_done) begin
        refresh_done_flag_r <= 1'b1;
      end else if (wr && !wave_hit && wb_sel_i[0] && wb_dat_i[0]
                   && {wb_adr_i[7:2], 2'b00} == OFS_INTF) begin
        refresh_done_flag_r <= 1'b0;
      end
      if (wr && !wave_hit && wb_sel_i[0]
          && {wb_adr_i[7:2], 2'b00} == OFS_INTE) begin
        refresh_done_irq_en_r <= wb_dat_i[0];
      end
    end
  end

  assign irq_o = refresh_done_flag_r && refresh_done_irq_en_r;

  // ==========================================================
  // Pin drive; controller off means every pin floats
  assign wave_drive = controller_on && !direct_drive_select
                      && seq_active;
  assign direct_drive = controller_on && direct_drive_select;
  assign pin_en = {back_plane_out_en_r, segment_out_en_r};

  generate
    for (genvar p = 0; p < PIN_N; p++) begin : g_pin
      eds_pin_cell u_cell (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .en_i(pin_en[p]),
        .direct_i(direct_drive),
        .wave_i(wave_drive),
        .float_i(cur_word[W_FLOAT]),
        .levels_i(cur_word[W_LVL +: 4]),
        .cur_i(cur_r[p]),
        .tgt_i(tgt_r[p]),
        .direct_lvl_i(nxt_r[p]),
        .pin_o(pin_lvl[p]),
        .oe_n_o(pin_oe_n[p])
      );
    end
  endgenerate

  assign segment_pin_o = pin_lvl[SEG_N-1:0];
  assign segment_pin_oe_n_o = pin_oe_n[SEG_N-1:0];
  assign back_plane_pin_o = pin_lvl[SEG_N];
  assign back_plane_pin_oe_n_o = pin_oe_n[SEG_N];

  // Top plane ignores the float bit, follows bit 12 in waveform mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      top_plane_pin_o <= 1'b0;
      top_plane_pin_oe_n_o <= 1'b1;
    end else if (ce_i) begin
      if (!top_plane_out_en_r) begin
        top_plane_pin_oe_n_o <= 1'b1;
      end else if (direct_drive) begin
        top_plane_pin_o <= top_plane_level_r;
        top_plane_pin_oe_n_o <= 1'b0;
      end else if (wave_drive) begin
        top_plane_pin_o <= cur_word[W_TP];
        top_plane_pin_oe_n_o <= 1'b0;
      end else begin
        top_plane_pin_oe_n_o <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_ack_next_cycle: assert property (
    (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle after request");
  a_done_sets_flag: assert property (
    (seq_done) |=> refresh_done_flag_r)
    else $error("done did not set the flag");
  a_flag_clears: assert property (
    (ce_i && !seq_done && refresh_kick == 1'b0 && wr && !wave_hit
     && wb_sel_i[0] && wb_dat_i[0] && wb_adr_i == OFS_INTF)
    |=> !refresh_done_flag_r)
    else $error("write one did not clear the flag");
  a_busy_on_kick: assert property (
    (ce_i && seq_start) |=> refresh_active_o ##0 !refresh_done_flag_r
    || refresh_active_o)
    else $error("busy did not rise on trigger");
  a_busy_kick_dropped: assert property (
    (ce_i && refresh_kick && seq_active) |=> tgt_r == $past(tgt_r))
    else $error("trigger during a run reloaded the data");
  a_tp_follows_set: assert property (
    (ce_i && wave_drive && top_plane_out_en_r)
    |=> (!top_plane_pin_oe_n_o
         && top_plane_pin_o == $past(cur_word[W_TP])))
    else $error("top plane did not follow set bit 12");
  a_float_set: assert property (
    (ce_i && wave_drive && cur_word[W_FLOAT])
    |=> (&segment_pin_oe_n_o && back_plane_pin_oe_n_o))
    else $error("segments driven during a float set");
  a_idle_floats: assert property (
    (ce_i && !direct_drive && !wave_drive)
    |=> (&segment_pin_oe_n_o && top_plane_pin_oe_n_o))
    else $error("pins driven outside a run");
  a_direct_level: assert property (
    (ce_i && direct_drive && segment_out_en_r[0])
    |=> (!segment_pin_oe_n_o[0]
         && segment_pin_o[0] == $past(nxt_r[0])))
    else $error("direct level not on segment 0");
  a_seg_level_pick: assert property (
    (ce_i && wave_drive && !cur_word[W_FLOAT] && segment_out_en_r[0])
    |=> (segment_pin_o[0] ==
         $past(cur_word[W_LVL + {cur_r[0], tgt_r[0]}])))
    else $error("segment 0 level not from transition bits");

  c_kick_taken: cover property (seq_start);
  c_done_irq: cover property (seq_done ##1 irq_o);
  c_direct_drive: cover property (direct_drive && !segment_pin_oe_n_o[0]);
  c_float_set: cover property (wave_drive && cur_word[W_FLOAT]);

endmodule : eds_waveform_ctrl

/* File: verification/eds_panel_model.sv */
// Panel electrode model: the level each pin really shows.
// Assumes oe_n low means the controller drives that pin.
module eds_panel_model
  import eds_pkg::*;
(
  input wire logic clk_i,
  input wire logic [PIN_N:0] pin_i,
  input wire logic [PIN_N:0] oe_n_i,
  output logic [PIN_N:0] lvl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [PIN_N:0] last_r = '0;
  // ==========================================================
  // Floating pins flip every cycle, so a stale level never passes
  always_ff @(posedge clk_i) begin
    last_r <= lvl_o;
  end
  assign lvl_o = (pin_i & ~oe_n_i) | (~last_r & oe_n_i);
endmodule : eds_panel_model

/* File: verification/epd_drive_waveform_sequencer_test.sv */
// Self-checking bench: register access, waveform runs, direct drive.
// Assumes the slave acks one cycle after taking a request.
module epd_drive_waveform_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  import eds_pkg::*;
  logic clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic [3:0] wb_sel_i = 4'hF, rcon, hcon;
  logic [1:0] hsel;
  logic ack, irq, act, pld, bp, bpz, tp, tpz;
  logic [SEG_N-1:0] seg, segz;
  logic [PIN_N:0] lvl;
  int errors = 0, compares = 0, cycles = 0, n = 0;
  // ==========================================================
  // Device, panel and clock
  eds_waveform_ctrl i_eds_waveform_ctrl (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(1'b1), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(ack),
    .irq_o(irq), .ref_reg_power_o(), .ref_level_select_o(),
    .doubler_power_o(), .doubler_bypass_o(), .ref_reg_heavy_load_o(),
    .ref_reg_contrast_o(rcon), .hv_reg_power_o(), .booster_power_o(),
    .booster_pulldown_o(pld), .hv_reg_heavy_load_o(),
    .hv_level_select_o(hsel), .hv_reg_contrast_o(hcon),
    .pin_drain_enable_o(), .driver_map_select_o(),
    .refresh_active_o(act), .segment_pin_o(seg),
    .segment_pin_oe_n_o(segz), .back_plane_pin_o(bp),
    .back_plane_pin_oe_n_o(bpz), .top_plane_pin_o(tp),
    .top_plane_pin_oe_n_o(tpz));
  eds_panel_model i_eds_panel_model (.clk_i(clk_i),
    .pin_i({tp, bp, seg}), .oe_n_i({tpz, bpz, segz}), .lvl_o(lvl));
  always #5 clk_i = ~clk_i;
  // Hang guard, well above the fewer than two hundred cycles the tests need
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      final_report();
    end
  end
  // ==========================================================
  // Bus and compare tasks
  task automatic bus(input logic [7:0] a, input logic [31:0] d,
                     input logic we);
    @(posedge clk_i);
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    wb_we_i <= we;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    // Ack and read data are taken at the same rising edge
    do @(posedge clk_i); while (ack !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 32'h0, 1'b0);
    chk(q, exp);
  endtask : rdc
  task automatic final_report();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  // ==========================================================
  // Test sequence
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(OFS_CTL, RST_CTL);
    chk({tpz, segz[1:0]}, 32'h7);
    // Power chain: doubled low reference, booster, then high voltage
    bus(OFS_PWR0, 32'h0000_0A05, 1'b1);
    chk(rcon, 32'hA);
    bus(OFS_PWR0, 32'h0000_0F0B, 1'b1);
    rdc(OFS_PWR0, 32'h0000_0F0B);
    bus(OFS_PWR1, 32'h0000_0C26, 1'b1);
    chk({hsel, pld, hcon}, 32'h5C);
    bus(OFS_PWR1, 32'h0000_0C37, 1'b1);
    rdc(OFS_PWR1, 32'h0000_0C27);
    rdc(8'h40, 32'h0);
    $display("power and register test done");
    // Timing sets: top plane up, white-to-black up, then float and end
    bus(OFS_WAVE, 32'h0000_5202, 1'b1);
    rdc(OFS_WAVE, 32'h0000_1202);
    bus(OFS_WAVE + 8'h7C, 32'h0000_FFFF, 1'b1);
    rdc(OFS_WAVE + 8'h7C, 32'h0000_BFFF);
    bus(OFS_WAVE + 8'h04, 32'h0000_A000, 1'b1);
    bus(OFS_OUTEN, 32'h3, 1'b1);
    bus(OFS_SEGEN0, 32'hFFFF_FFFF, 1'b1);
    bus(OFS_SEGD0, 32'h1, 1'b1);
    bus(OFS_INTE, 32'h1, 1'b1);
    bus(OFS_CTL, 32'h1, 1'b1);
    bus(OFS_TRIG, 32'h1, 1'b1);
    chk(act, 32'h1);
    @(negedge clk_i);
    chk({lvl[PIN_N], lvl[1:0], segz[1:0]}, 32'h14);
    repeat (3) @(negedge clk_i);
    // Set 1 period: top plane low, segments and back plane float
    chk({lvl[PIN_N], segz[1:0], bpz, act}, 32'hE);
    repeat (10) if (act === 1'b1) @(negedge clk_i);
    @(negedge clk_i);
    rdc(OFS_INTF, 32'h1);
    chk({irq, tpz, segz[1:0]}, 32'hF);
    bus(OFS_INTF, 32'h1, 1'b1);
    rdc(OFS_INTF, 32'h0);
    chk(irq, 32'h0);
    // Set 0 of 65 cycles; a second kick mid-run must not restart it
    bus(OFS_WAVE, 32'h0000_1240, 1'b1);
    bus(OFS_TRIG, 32'h1, 1'b1);
    bus(OFS_TRIG, 32'h1, 1'b1);
    rdc(OFS_TRIG, 32'h1);
    n = 0;
    while (act === 1'b1) begin
      @(negedge clk_i);
      n++;
    end
    // 66 busy cycles; seven fall in the three accesses, and n also counts the edge where busy falls
    chk(n, 32'd60);
    $display("waveform test done");
    // Direct drive, then a partial segment enable, then controller off
    bus(OFS_CTL, 32'h5, 1'b1);
    // No waveform run may start in direct mode
    bus(OFS_TRIG, 32'h1, 1'b1);
    rdc(OFS_TRIG, 32'h0);
    bus(OFS_PLDATA, 32'h1, 1'b1);
    bus(OFS_SEGD0, 32'h2, 1'b1);
    repeat (2) @(negedge clk_i);
    chk({lvl[PIN_N], lvl[1:0], segz[1:0]}, 32'h18);
    bus(OFS_SEGEN0, 32'h1, 1'b1);
    repeat (2) @(negedge clk_i);
    chk(segz[1:0], 32'h2);
    bus(OFS_CTL, 32'h4, 1'b1);
    repeat (2) @(negedge clk_i);
    chk({tpz, segz[0]}, 32'h3);
    $display("direct drive test done");
    final_report();
  end
endmodule : epd_drive_waveform_sequencer_test
